// file: fault_pkg.sv
// Purpose: Shared types and constants for the paper path fault monitor
// Assumes: 250 MHz system clock, APB register access with 32-bit data
// Notes:   Jam codes are held as three hex digits; the leading E is implied

package fault_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 4000;               // 250 MHz clock
	localparam int TICK_TIME_US = 1000;                // Common timeout tick, 1 ms
	localparam int TICK_CYCLES = TICK_TIME_US * 1000000 / CLK_PERIOD_PS;
	localparam int LEAD_EXIT_TIME_MS = 1200;           // Exit must arrive after clutch on
	localparam int TRAIL_EXIT_TIME_MS = 1300;          // Exit must clear after clutch off
	localparam logic [11:0] LEAD_EXIT_TICKS = 12'(LEAD_EXIT_TIME_MS * 1000 / TICK_TIME_US);
	localparam logic [11:0] TRAIL_EXIT_TICKS = 12'(TRAIL_EXIT_TIME_MS * 1000 / TICK_TIME_US);
	localparam logic [1:0] STARTUP_CHECK = 2'h2;       // Cycle where synced pins are valid

	// ----------------------------------------------------------------
	// Timers, one per supervised sensor interval
	// ----------------------------------------------------------------
	localparam int NT = 9;
	localparam int T_TRAY = 0;                         // Tray top after lift start
	localparam int T_BYPASS = 1;                       // Registration after bypass clutch
	localparam int T_LEAD = 2;                         // Exit on after registration clutch
	localparam int T_TRAIL = 3;                        // Exit off after registration clutch off
	localparam int T_TRANSPORT = 4;                    // Registration after transport roller
	localparam int T_DUPFEED = 5;                      // Registration after duplex clutch
	localparam int T_DUPENTRY = 6;                     // Duplex entry after path start
	localparam int T_DUPEXIT = 7;                      // Duplex exit after entry
	localparam int T_FEED = 8;                         // Registration after drawer clutch
	localparam int NTMO = 6;                           // Programmable timeout registers

	// ----------------------------------------------------------------
	// Jam codes
	// ----------------------------------------------------------------
	localparam logic [11:0] CODE_NONE = 12'h000;
	localparam logic [11:0] CODE_LEAD = 12'h010;
	localparam logic [11:0] CODE_TRAIL = 12'h020;
	localparam logic [11:0] CODE_RESIDUAL = 12'h030;
	localparam logic [11:0] CODE_DUPFEED = 12'h110;
	localparam logic [11:0] CODE_BYPASS = 12'h120;
	localparam logic [11:0] CODE_COVER = 12'h410;
	localparam logic [11:0] CODE_DUPENTRY = 12'h510;
	localparam logic [11:0] CODE_DUPEXIT = 12'h520;
	// Indexed by paper source: upper, lower, pedestal, high capacity
	localparam logic [11:0] CODE_REG [4] = '{12'h200, 12'h210, 12'h300, 12'h3c0};
	localparam logic [11:0] CODE_FEED [4] = '{12'h220, 12'h310, 12'h3d0, 12'h3e0};

	// ----------------------------------------------------------------
	// Register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_JAM_CODE = 8'h04;
	localparam logic [7:0] ADDR_TMO_BASE = 8'h08;     // Six timeouts, one word each
	localparam logic [7:0] ADDR_TMO_LAST = 8'h1c;
	localparam logic [11:0] TMO_RESET [NTMO] = '{12'h1f4, 12'h1f4, 12'h1f4, 12'h1f4,
		12'h1f4, 12'h1f4};                             // 500 ms each after reset
	localparam int TMO_TRAY = 0;
	localparam int TMO_BYPASS = 1;
	localparam int TMO_TRANSPORT = 2;
	localparam int TMO_DUPFEED = 3;
	localparam int TMO_DUPPATH = 4;
	localparam int TMO_FEED = 5;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic drawer_present;
		logic tray_top;
		logic paper_empty_ok;                          // Empty sensor on: paper under it
		logic transport;
		logic registration_sensor;
		logic exit_sensor;
		logic bypass_tray_paper_sensor;
		logic duplex_entry;
		logic duplex_exit;
		logic toner_present;
		logic developer_connected;
		logic waste_bag_full_sensor;
		logic front_cover_open;
	} sensors_t;

	typedef struct packed {
		logic copy_active;
		logic printing;
		logic drawer_selected;
		logic bypass_feed_clutch;
		logic duplex_feed_clutch;
		logic registration_clutch;
		logic drawer_feed_clutch;
		logic duplex_path_start;
		logic service_call;
		logic [1:0] feed_source;
	} ctrl_t;

	typedef enum logic [2:0] {LIFT_OFF, LIFT_INIT, LIFT_READY, LIFT_TOPUP, LIFT_FAULT} lift_t;

endpackage : fault_pkg

// file: paper_path_fault_monitor.sv
// Purpose: Paper path, tray lift and consumable fault monitor with APB status
// Assumes: Sensor pins are asynchronous; sequencer controls share clock_i
// Notes:   A main switch cycle is a power-on reset of this block
//
// Notes on behaviour
// - Faults clear by self, door, or power
// - No drawer or paper: flag, blink, inhibit
// - Lift timeout gives tray fault until reset
// - Tray top stops lift; empty sensor judges
// - Tray top lost in copy restarts lift
// - Empty off while top on stops copy
// - Bypass clutch without registration gives E120
// - Bypass tray emptied clears bypass misfeed
// - Exit late after registration clutch: E010
// - Exit stuck after clutch off: E020
// - Paper in path at power-up: E030
// - Cover opened during copy gives E410
// - Registration late after transport roller: jam
// - Registration late after duplex clutch: E110
// - Duplex entry or exit missed: E510/E520
// - Registration late after feed clutch: source code
// - Toner absent disables copying until supplied
// - Developer disconnected shows not installed
// - Waste bag full raises dispose indication
// - Bag full in print: finish sheet, stop

`timescale 1ns/1ps

module paper_path_fault_monitor #(
	parameter int TICK_CYC = fault_pkg::TICK_CYCLES    // Cycles per 1 ms tick
) (
	// Clock, reset, enable
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Sensor pins, asynchronous
	input wire fault_pkg::sensors_t sens_i,
	// Sequencer controls, same clock
	input wire fault_pkg::ctrl_t ctrl_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Machine and panel outputs
	output logic tray_lift_motor_o,
	output logic no_paper_o,
	output logic drawer_blink_o,
	output logic start_inhibit_o,
	output logic copy_stop_o,
	output logic print_stop_o,
	output logic replace_toner_o,
	output logic developer_missing_o,
	output logic dispose_toner_o,
	output logic service_call_o,
	output logic jam_o,
	output logic [11:0] jam_code_o
);
	import fault_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		sensors_t sync1;                               // First synchroniser stage
		sensors_t sync2;                               // Second stage, safe to read
		sensors_t prev;                                // For edge detection
		ctrl_t cprev;                                  // Previous controls
		logic [17:0] tick_cnt;                         // Millisecond prescaler
		logic [NT-1:0] trun;                           // Timer running
		logic [NT-1:0][11:0] tcnt;                     // Timer elapsed ms
		logic [NTMO-1:0][11:0] tmo;                    // Programmable timeouts
		lift_t lift;                                   // Tray lift sequence
		logic paper_absent;                            // Judged no paper
		logic tray_fault;
		logic bypass_misfeed;
		logic jam;
		logic toner_empty;
		logic dev_missing;
		logic bag_full;
		logic bag_stop;                                // Printing halted for bag
		logic service;
		logic [1:0] startup;
		logic [11:0] code;
		logic [31:0] rdata;
	} state_t;

	state_t s, n;

	// ----------------------------------------------------------------
	// Combinational helpers
	// ----------------------------------------------------------------
	logic tick;
	logic [NT-1:0] arm, done, fire;
	logic [NT-1:0][11:0] limit;
	logic [NT-1:0][11:0] code_of;
	logic [31:0] status_w;
	logic addr_ok;
	logic door_close, cover_rise, drawer_rise, exit_fall, bypass_fall;
	logic new_jam;
	logic [11:0] new_code;

	// Sensor edges, all from the settled stage
	assign door_close = s.prev.front_cover_open & ~s.sync2.front_cover_open;
	assign cover_rise = ~s.prev.front_cover_open & s.sync2.front_cover_open;
	assign drawer_rise = ~s.prev.drawer_present & s.sync2.drawer_present;
	assign exit_fall = s.prev.exit_sensor & ~s.sync2.exit_sensor;
	assign bypass_fall = s.prev.bypass_tray_paper_sensor & ~s.sync2.bypass_tray_paper_sensor;
	assign tick = (s.tick_cnt == 18'(TICK_CYC - 1));

	// Arm, done and limit per timer
	always_comb begin
		arm = '0;
		done = '0;
		arm[T_TRAY] = drawer_rise & ~s.tray_fault;
		done[T_TRAY] = s.sync2.tray_top;
		arm[T_BYPASS] = ctrl_i.bypass_feed_clutch & ~s.cprev.bypass_feed_clutch;
		done[T_BYPASS] = s.sync2.registration_sensor;
		arm[T_LEAD] = ctrl_i.registration_clutch & ~s.cprev.registration_clutch;
		done[T_LEAD] = s.sync2.exit_sensor;
		arm[T_TRAIL] = ~ctrl_i.registration_clutch & s.cprev.registration_clutch;
		done[T_TRAIL] = ~s.sync2.exit_sensor;
		arm[T_TRANSPORT] = s.sync2.transport & ~s.prev.transport;
		done[T_TRANSPORT] = s.sync2.registration_sensor;
		arm[T_DUPFEED] = ctrl_i.duplex_feed_clutch & ~s.cprev.duplex_feed_clutch;
		done[T_DUPFEED] = s.sync2.registration_sensor;
		arm[T_DUPENTRY] = ctrl_i.duplex_path_start & ~s.cprev.duplex_path_start;
		done[T_DUPENTRY] = s.sync2.duplex_entry;
		arm[T_DUPEXIT] = s.sync2.duplex_entry & ~s.prev.duplex_entry;
		done[T_DUPEXIT] = s.sync2.duplex_exit;
		arm[T_FEED] = ctrl_i.drawer_feed_clutch & ~s.cprev.drawer_feed_clutch;
		done[T_FEED] = s.sync2.registration_sensor;
	end

	// Fixed exit limits; the rest come from software
	always_comb begin
		limit[T_TRAY] = s.tmo[TMO_TRAY];
		limit[T_BYPASS] = s.tmo[TMO_BYPASS];
		limit[T_LEAD] = LEAD_EXIT_TICKS;
		limit[T_TRAIL] = TRAIL_EXIT_TICKS;
		limit[T_TRANSPORT] = s.tmo[TMO_TRANSPORT];
		limit[T_DUPFEED] = s.tmo[TMO_DUPFEED];
		limit[T_DUPENTRY] = s.tmo[TMO_DUPPATH];
		limit[T_DUPEXIT] = s.tmo[TMO_DUPPATH];
		limit[T_FEED] = s.tmo[TMO_FEED];
		code_of[T_TRAY] = CODE_NONE;
		code_of[T_BYPASS] = CODE_BYPASS;
		code_of[T_LEAD] = CODE_LEAD;
		code_of[T_TRAIL] = CODE_TRAIL;
		code_of[T_TRANSPORT] = CODE_REG[ctrl_i.feed_source];
		code_of[T_DUPFEED] = CODE_DUPFEED;
		code_of[T_DUPENTRY] = CODE_DUPENTRY;
		code_of[T_DUPEXIT] = CODE_DUPEXIT;
		code_of[T_FEED] = CODE_FEED[ctrl_i.feed_source];
	end

	// Expiry: a timer fires on the tick that reaches its limit
	always_comb begin
		for (int i = 0; i < NT; i++) begin
			fire[i] = s.trun[i] & ~done[i] & tick & ((s.tcnt[i] + 12'h001) >= limit[i]);
		end
	end

	// Pick one equipment jam; the lowest timer index wins a tie
	always_comb begin
		new_jam = 1'b0;
		new_code = CODE_NONE;
		if (ctrl_i.copy_active & cover_rise) begin
			new_jam = 1'b1;
			new_code = CODE_COVER;
		end
		if (s.startup == STARTUP_CHECK && (s.sync2.transport | s.sync2.registration_sensor |
			s.sync2.exit_sensor | s.sync2.duplex_entry | s.sync2.duplex_exit)) begin
			new_jam = 1'b1;
			new_code = CODE_RESIDUAL;
		end
		for (int i = NT - 1; i > T_BYPASS; i--) begin
			if (fire[i]) begin
				new_jam = 1'b1;
				new_code = code_of[i];
			end
		end
	end

	// Status word
	always_comb begin
		status_w = '0;
		status_w[0] = no_paper_o;
		status_w[1] = s.paper_absent;
		status_w[2] = s.tray_fault;
		status_w[3] = s.bypass_misfeed;
		status_w[4] = s.jam;
		status_w[5] = s.toner_empty;
		status_w[6] = s.dev_missing;
		status_w[7] = s.bag_full;
		status_w[8] = s.service;
		status_w[9] = s.bag_stop;
		status_w[10] = tray_lift_motor_o;
	end

	assign addr_ok = (paddr_i[1:0] == 2'h0) && (paddr_i <= ADDR_TMO_LAST);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n = s;
		// Pins through two flops before use
		n.sync1 = sens_i;
		n.sync2 = s.sync1;
		n.prev = s.sync2;
		n.cprev = ctrl_i;
		n.tick_cnt = tick ? 18'h00000 : s.tick_cnt + 18'h00001;
		if (s.startup != 2'h3) begin
			n.startup = s.startup + 2'h1;
		end
		// Independent timers
		for (int i = 0; i < NT; i++) begin
			if (arm[i]) begin
				n.trun[i] = 1'b1;
				n.tcnt[i] = 12'h000;
			end else if (done[i] | fire[i]) begin
				n.trun[i] = 1'b0;
			end else if (s.trun[i] & tick) begin
				n.tcnt[i] = s.tcnt[i] + 12'h001;
			end
		end
		// Tray lift sequence
		unique case (s.lift)
			LIFT_OFF: begin
				if (drawer_rise) begin
					n.lift = LIFT_INIT;
				end
			end
			LIFT_INIT: begin
				if (fire[T_TRAY]) begin
					n.lift = LIFT_FAULT;
					n.tray_fault = 1'b1;
				end else if (!s.sync2.drawer_present) begin
					n.lift = LIFT_OFF;
				end else if (s.sync2.tray_top) begin
					n.lift = LIFT_READY;
					n.paper_absent = ~s.sync2.paper_empty_ok;
				end
			end
			LIFT_READY: begin
				if (!s.sync2.drawer_present) begin
					n.lift = LIFT_OFF;
				end else if (ctrl_i.copy_active & ~s.sync2.tray_top) begin
					n.lift = LIFT_TOPUP;
				end else if (ctrl_i.copy_active & ~s.sync2.paper_empty_ok) begin
					n.paper_absent = 1'b1;
				end
			end
			LIFT_TOPUP: begin
				// Rerun is not timed; the sheet flow stalls visibly if it fails
				if (!s.sync2.drawer_present) begin
					n.lift = LIFT_OFF;
				end else if (s.sync2.tray_top) begin
					n.lift = LIFT_READY;
				end
			end
			LIFT_FAULT: begin
				n.lift = LIFT_FAULT;
			end
			default: begin
				n.lift = LIFT_OFF;
			end
		endcase
		// Self-clearing group
		if (fire[T_BYPASS]) begin
			n.bypass_misfeed = 1'b1;
		end else if (bypass_fall) begin
			n.bypass_misfeed = 1'b0;
		end
		// Door group: set wins over the door close
		if (new_jam) begin
			n.jam = 1'b1;
		end else if (door_close) begin
			n.jam = 1'b0;
		end
		if (!s.sync2.toner_present && s.startup >= STARTUP_CHECK) begin
			n.toner_empty = 1'b1;
		end else if (door_close) begin
			n.toner_empty = 1'b0;
		end
		if (!s.sync2.developer_connected && s.startup >= STARTUP_CHECK) begin
			n.dev_missing = 1'b1;
		end else if (door_close) begin
			n.dev_missing = 1'b0;
		end
		if (s.sync2.waste_bag_full_sensor) begin
			n.bag_full = 1'b1;
		end else if (door_close) begin
			n.bag_full = 1'b0;
		end
		// A sheet already past the exit lets one more sheet through
		if (s.bag_full & (~ctrl_i.printing | exit_fall)) begin
			n.bag_stop = 1'b1;
		end else if (!n.bag_full) begin
			n.bag_stop = 1'b0;
		end
		// Power group: only reset clears these
		if (ctrl_i.service_call) begin
			n.service = 1'b1;
		end
		// First code kept while any coded fault stands
		if ((new_jam | fire[T_BYPASS]) && (s.code == CODE_NONE || (!s.jam && !s.bypass_misfeed))) begin
			n.code = new_jam ? new_code : CODE_BYPASS;
		end else if (!n.jam && !n.bypass_misfeed) begin
			n.code = CODE_NONE;
		end
		// APB: read data captured in setup, writes at the access edge
		if (psel_i & ~penable_i) begin
			n.rdata = '0;
			if (paddr_i == ADDR_STATUS) begin
				n.rdata = status_w;
			end else if (paddr_i == ADDR_JAM_CODE) begin
				n.rdata = {20'h00000, s.code};
			end else if (addr_ok) begin
				n.rdata = {20'h00000, s.tmo[3'((paddr_i - ADDR_TMO_BASE) >> 2)]};
			end
		end
		if (psel_i & penable_i & pwrite_i & addr_ok && paddr_i >= ADDR_TMO_BASE) begin
			n.tmo[3'((paddr_i - ADDR_TMO_BASE) >> 2)] = pwdata_i[11:0];
		end
	end

	// ----------------------------------------------------------------
	// Registers, frozen while the enable is low
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
			for (int i = 0; i < NTMO; i++) begin
				s.tmo[i] <= TMO_RESET[i];
			end
		end else if (ce_i) begin
			s <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Ready follows the enable so no write lands in a frozen cycle
	assign pready_o = ce_i;
	assign pslverr_o = psel_i & penable_i & ~addr_ok;
	assign prdata_o = s.rdata;
	assign tray_lift_motor_o = (s.lift == LIFT_INIT) | (s.lift == LIFT_TOPUP);
	assign no_paper_o = ~s.sync2.drawer_present | s.paper_absent | s.tray_fault;
	assign drawer_blink_o = no_paper_o & ctrl_i.drawer_selected;
	assign copy_stop_o = s.jam | s.bypass_misfeed | s.toner_empty | s.dev_missing |
		s.service | s.paper_absent | s.tray_fault | s.bag_stop;
	assign start_inhibit_o = copy_stop_o | no_paper_o | s.bag_full;
	assign print_stop_o = s.bag_stop;
	assign replace_toner_o = s.toner_empty;
	assign developer_missing_o = s.dev_missing;
	assign dispose_toner_o = s.bag_full;
	assign service_call_o = s.service;
	assign jam_o = s.jam;
	assign jam_code_o = s.code;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_init_top;
		ce_i && s.lift == LIFT_INIT && s.sync2.tray_top && s.sync2.drawer_present && !fire[T_TRAY];
	endsequence

	chk_tray_fault_sticky: assert property (s.tray_fault |=> s.tray_fault && no_paper_o)
		else $error("tray fault dropped before reset");
	chk_top_stops_lift: assert property (s_init_top |=> !tray_lift_motor_o)
		else $error("lift motor still on after tray top");
	chk_topup_restart: assert property (ce_i && s.lift == LIFT_READY && s.sync2.drawer_present
		&& ctrl_i.copy_active && !s.sync2.tray_top |=> tray_lift_motor_o)
		else $error("lift not restarted when tray top lost");
	chk_blink_selected: assert property (ctrl_i.drawer_selected && !s.sync2.drawer_present
		|-> drawer_blink_o && start_inhibit_o)
		else $error("blink without inhibited start");
	chk_bypass_clear: assert property (ce_i && s.bypass_misfeed && bypass_fall
		&& !fire[T_BYPASS] |=> !s.bypass_misfeed)
		else $error("bypass misfeed not cleared by empty tray");
	chk_cover_jam: assert property (ce_i && ctrl_i.copy_active && cover_rise
		|=> s.jam && copy_stop_o)
		else $error("cover open in copy gave no jam");
	chk_lead_code: assert property (ce_i && fire[T_LEAD] && s.code == CODE_NONE && !cover_rise
		&& s.startup == 2'h3 |=> s.code == CODE_LEAD)
		else $error("leading edge jam code wrong");
	chk_code_held: assert property (ce_i && s.jam && s.code != CODE_NONE && !door_close
		|=> $stable(s.code))
		else $error("latched jam code changed");
	chk_toner_stops: assert property (ce_i && !s.sync2.toner_present && s.startup >= STARTUP_CHECK
		|=> s.toner_empty ##0 copy_stop_o)
		else $error("toner empty did not stop copying");
	chk_service_sticky: assert property (s.service |=> s.service)
		else $error("service call cleared without reset");

endmodule : paper_path_fault_monitor

// file: sensor_model.sv
// Purpose: Tray and sensor model facing the fault monitor
// Assumes: Tray tops out after lift_dly_i cycles of motor run
// Notes:   lift_dly_i of 8'hff never tops out, a stuck tray

`timescale 1ns/1ps

module sensor_model (
	// Clock and motor
	input wire logic clock_i,
	input wire logic motor_i,
	// Bench settings
	input wire logic [7:0] lift_dly_i,
	input wire fault_pkg::sensors_t pins_i,
	// Pins to the monitor
	output fault_pkg::sensors_t sens_o
);
	import fault_pkg::*;
	logic [7:0] lift_q = 8'h00; // Motor run so far
	// Tray climbs only while the motor runs; drops when pulled
	always_ff @(posedge clock_i) begin
		if (!pins_i.drawer_present) lift_q <= 8'h00;
		else if (motor_i && lift_q != 8'hfe) lift_q <= lift_q + 8'h01;
	end
	// Top sensor follows tray height, never on for a stuck tray
	always_comb begin
		sens_o = pins_i;
		sens_o.tray_top = pins_i.drawer_present && lift_dly_i != 8'hff && lift_q >= lift_dly_i;
	end
endmodule : sensor_model

// file: paper_path_fault_monitor_tb.sv
// Purpose: Self-checking bench for the paper path fault monitor
// Assumes: 1 ms tick shortened to 10 cycles
// Notes:   Expected codes and timings worked out from tick counts

`timescale 1ns/1ps

module paper_path_fault_monitor_tb;
	import fault_pkg::*;
	logic clock_i = 0, rst_n_i = 0, ce_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [7:0] paddr_i = 8'h00, lift_dly = 8'hff;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd, seed = 32'h855c4bd3;
	logic pready_o, pslverr_o, tray_lift_motor_o, no_paper_o, drawer_blink_o, err;
	logic start_inhibit_o, copy_stop_o, print_stop_o, replace_toner_o;
	logic developer_missing_o, dispose_toner_o, service_call_o, jam_o;
	logic [11:0] jam_code_o, tmo_exp [NTMO]; // Expected timeout registers
	sensors_t pins = '0, sens_i;
	ctrl_t ctrl_i = '0;
	int num_errors = 0, n_tests = 0, n, cyc = 0;
	always #2 clock_i = ~clock_i;
	sensor_model i_model (.clock_i(clock_i), .motor_i(tray_lift_motor_o), .lift_dly_i(lift_dly),
		.pins_i(pins), .sens_o(sens_i));
	paper_path_fault_monitor #(.TICK_CYC(10)) i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.ce_i(ce_i), .sens_i(sens_i), .ctrl_i(ctrl_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .tray_lift_motor_o(tray_lift_motor_o),
		.no_paper_o(no_paper_o), .drawer_blink_o(drawer_blink_o),
		.start_inhibit_o(start_inhibit_o), .copy_stop_o(copy_stop_o),
		.print_stop_o(print_stop_o), .replace_toner_o(replace_toner_o),
		.developer_missing_o(developer_missing_o), .dispose_toner_o(dispose_toner_o),
		.service_call_o(service_call_o), .jam_o(jam_o), .jam_code_o(jam_code_o));
	// Compare one result, report at once
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Bounded wait for a level; a miss counts as a mismatch
	task automatic wait_for(ref logic sig, input logic val, input int lim);
		n = 0;
		while (sig !== val && n < lim) begin
			@(posedge clock_i);
			n++;
		end
		chk(n < lim, 1);
	endtask : wait_for
	// One APB transfer: setup, then access until pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clock_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do @(posedge clock_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	// Reset held three cycles, like a main switch cycle
	task automatic power_cycle();
		@(posedge clock_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		rst_n_i <= 1'b1;
	endtask : power_cycle
	// Single place where the run ends
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up
	// Hang guard, well above the longest 500 ms and 1.2 s waits
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			wrap_up();
		end
	end
	initial begin
		// Stuck tray and paper at the exit at power-up
		pins.drawer_present = 1;
		pins.paper_empty_ok = 1;
		pins.toner_present = 1;
		pins.developer_connected = 1;
		pins.exit_sensor = 1;
		power_cycle();
		wait_for(jam_o, 1, 20);
		chk(jam_code_o, 12'h030);
		wait_for(tray_lift_motor_o, 1, 20);
		wait_for(tray_lift_motor_o, 0, 6000);
		chk(n > 4950, 1);
		apb(0, ADDR_STATUS, 0);
		chk({rd[4], rd[2], rd[0], start_inhibit_o}, 4'hf);
		// Healthy tray after a second power cycle
		pins.exit_sensor <= 0;
		lift_dly <= 8'h05;
		power_cycle();
		wait_for(tray_lift_motor_o, 1, 20);
		wait_for(tray_lift_motor_o, 0, 100);
		repeat (3) @(posedge clock_i);
		chk({no_paper_o, start_inhibit_o, jam_o}, 3'b000);
		// Drawer pulled while selected, then reinserted
		ctrl_i.drawer_selected <= 1;
		pins.drawer_present <= 0;
		repeat (5) @(posedge clock_i);
		chk({no_paper_o, drawer_blink_o, start_inhibit_o}, 3'b111);
		pins.drawer_present <= 1;
		wait_for(tray_lift_motor_o, 1, 20);
		wait_for(tray_lift_motor_o, 0, 100);
		repeat (3) @(posedge clock_i);
		chk({no_paper_o, copy_stop_o}, 2'b00);
		// Timeout registers: reset value, random write, readback
		for (int i = 0; i < NTMO; i++) begin
			apb(0, ADDR_TMO_BASE + 8'(4 * i), 0);
			chk(rd, {20'h0, TMO_RESET[i]});
			tmo_exp[i] = 12'($random(seed));
			apb(1, ADDR_TMO_BASE + 8'(4 * i), {20'($random(seed)), tmo_exp[i]});
			apb(0, ADDR_TMO_BASE + 8'(4 * i), 0);
			chk(rd, {20'h0, tmo_exp[i]});
		end
		apb(0, 8'h22, 0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		// Exit never arrives after the registration clutch
		ctrl_i.copy_active <= 1;
		ctrl_i.registration_clutch <= 1;
		wait_for(jam_o, 1, 13000);
		chk(n > 11980 && n < 12010, 1);
		chk({jam_code_o, copy_stop_o}, {12'h010, 1'b1});
		// Door cycle clears it; cover opened mid-copy jams again
		ctrl_i.registration_clutch <= 0;
		pins.front_cover_open <= 1;
		repeat (6) @(posedge clock_i);
		chk(jam_code_o, 12'h010);
		pins.front_cover_open <= 0;
		repeat (6) @(posedge clock_i);
		chk({jam_o, jam_code_o}, 0);
		pins.front_cover_open <= 1;
		repeat (6) @(posedge clock_i);
		chk(jam_code_o, 12'h410);
		ctrl_i.copy_active <= 0;
		pins.front_cover_open <= 0;
		// Bypass misfeed at 3 ms, cleared by emptying the tray
		apb(1, ADDR_TMO_BASE + 8'h04, 32'h3);
		pins.bypass_tray_paper_sensor <= 1;
		ctrl_i.bypass_feed_clutch <= 1;
		repeat (45) @(posedge clock_i);
		chk({jam_code_o, copy_stop_o}, {12'h120, 1'b1});
		pins.bypass_tray_paper_sensor <= 0;
		repeat (6) @(posedge clock_i);
		apb(0, ADDR_STATUS, 0);
		chk({rd[3], copy_stop_o}, 2'b00);
		// Pedestal drawer feed with no registration at 2 ms
		apb(1, ADDR_TMO_BASE + 8'h14, 32'h2);
		ctrl_i.feed_source <= 2'h2;
		ctrl_i.drawer_feed_clutch <= 1;
		repeat (35) @(posedge clock_i);
		chk({jam_o, jam_code_o}, {1'b1, 12'h3d0});
		// Empty sensor off while copying with the tray up
		ctrl_i.copy_active <= 1;
		ctrl_i.printing <= 1;
		pins.paper_empty_ok <= 0;
		repeat (6) @(posedge clock_i);
		chk({no_paper_o, drawer_blink_o, copy_stop_o}, 3'b111);
		// Consumables and service call
		pins.toner_present <= 0;
		pins.developer_connected <= 0;
		pins.waste_bag_full_sensor <= 1;
		ctrl_i.service_call <= 1;
		repeat (6) @(posedge clock_i);
		chk({replace_toner_o, developer_missing_o}, 2'h3);
		chk({dispose_toner_o, service_call_o, print_stop_o}, 3'h6);
		// Sheet in process leaves the exit, then printing stops
		pins.exit_sensor <= 1;
		repeat (4) @(posedge clock_i);
		pins.exit_sensor <= 0;
		repeat (6) @(posedge clock_i);
		chk(print_stop_o, 1'b1);
		wrap_up();
	end
endmodule : paper_path_fault_monitor_tb
